//--- logic/sac_pkg.sv
// sac_pkg: register map, field positions, reset values, timing and bus carriers
// for the sampled acquisition control block.
// assumes a 100 MHz system clock and a 32-bit APB master.
`default_nettype none
package sac_pkg;
	// register byte offsets
	localparam logic [7:0] SAC_CTRL_OFS = 8'h00;
	localparam logic [7:0] SAC_STAT_OFS = 8'h04;
	localparam logic [7:0] SAC_FIFO_OFS = 8'h08;
	localparam logic [7:0] SAC_MODE_OFS = 8'h0C;
	localparam logic [7:0] SAC_CNT0_OFS = 8'h10;
	// control fields
	localparam int SAC_CTRL_ACQ = 0;
	localparam int SAC_CTRL_SCAN = 1;
	localparam int SAC_CTRL_CH_LSB = 2;
	localparam int SAC_CTRL_EXT = 5;
	localparam int SAC_CTRL_OVCLR = 6;
	localparam int SAC_CTRL_FLUSH = 7;
	// status fields
	localparam int SAC_STAT_NE = 0;
	localparam int SAC_STAT_OVF = 1;
	localparam int SAC_STAT_CH_LSB = 2;
	localparam int SAC_STAT_BUSY = 5;
	// reset values
	localparam logic [5:0] SAC_CTRL_RST = 6'h00;
	localparam logic [7:0] SAC_MODE_RST = 8'h00;
	localparam logic [15:0] SAC_CNT_RST = 16'h0002;
	// widths and limits
	localparam int SAC_ADC_W = 12;
	localparam int SAC_WORD_W = 16;
	localparam int SAC_NCH = 8;
	localparam int SAC_NCNT = 3;
	localparam logic [15:0] SAC_CNT_MIN = 16'h0002;
	// timing: system clock and counter timebase
	localparam int SAC_CLK_KHZ = 100000;
	localparam int SAC_TB_KHZ = 1000;
	localparam int SAC_TICK_CYC = SAC_CLK_KHZ / SAC_TB_KHZ;
	localparam int SAC_EXT_LAT_NS = 20000;
	localparam int SAC_EXT_LAT_CYC = SAC_EXT_LAT_NS / 10;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} sac_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} sac_apb_rsp_t;

	typedef struct packed {
		logic start;
		logic [2:0] chan;
	} sac_adc_cmd_t;
endpackage
`default_nettype wire

//--- logic/sac_top.sv
// sac_top: timed acquisition control with sample timer, scan, and result FIFO.
// assumes an APB master, a converter that returns one done pulse per start,
// and synchronous inputs.
// Operation
// - sign-extend 12-bit result to 16 bits
// - drive one of eight channels 0..7
// - store result, converter free immediately
// - 16-word FIFO, overflow flags and drops
// - not-empty flag in status register
// - converter data is twos complement
// - convert on timer or external rising edge
// - 16-bit down counter on 1 MHz
// - count of one gives pulse and reload, repeats
// - single-channel mux held during acquisition
// - scan descends from highest, wraps around
// - scan of one to eight channels
// - three 16-bit counters, 8-bit mode
// - sample counter clocked from 1 MHz
// - external conversion stored within 20 us
// - sample counter runs only while mode bit 0 is set
`default_nettype none
module sac_top #(
	parameter int DEPTH = 16,
	parameter int TICK_CYC = sac_pkg::SAC_TICK_CYC
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// register bus
	input wire sac_pkg::sac_apb_req_t apb_in,
	output sac_pkg::sac_apb_rsp_t apb_out,
	// converter
	output sac_pkg::sac_adc_cmd_t adc_out,
	input wire logic adc_done_in,
	input wire logic [sac_pkg::SAC_ADC_W-1:0] adc_data_in,
	// timing pins
	input wire logic external_convert_n,
	output logic [sac_pkg::SAC_NCNT-1:0] timer_out_out
);
	import sac_pkg::*;
	localparam int AW = $clog2(DEPTH);
	localparam int TICK_GAP = TICK_CYC - 1;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);

	// registers
	logic [5:0] ctrl_q;
	logic [7:0] mode_q;
	logic [15:0] reload_q [SAC_NCNT];
	logic [15:0] cnt_q [SAC_NCNT];
	logic [SAC_NCNT-1:0] tout_q;
	logic [6:0] div_q;
	logic tick;
	logic [31:0] prdata_q;
	logic pready_q, pslverr_q;
	logic pop_ok_q;
	logic start_q, busy_q;
	logic [2:0] chan_q;
	logic tout0_prev_q, ext_prev_q;
	logic [SAC_WORD_W-1:0] mem_q [DEPTH];
	logic [AW-1:0] wp_q, rp_q;
	logic [AW:0] level_q;
	logic ovf_q;

	// bus decode
	logic setup_acc, done_acc, wr_acc, rd_acc;
	logic [31:0] rd_mux;
	logic rd_err;
	logic acq_en, scan_en, ext_en;
	logic [2:0] high_ch;
	logic push, pop, full, empty, ovcl, flush;
	logic tmr_rise, ext_rise, conv_req;

	assign acq_en = ctrl_q[SAC_CTRL_ACQ];
	assign scan_en = ctrl_q[SAC_CTRL_SCAN];
	assign high_ch = ctrl_q[SAC_CTRL_CH_LSB +: 3];
	assign ext_en = ctrl_q[SAC_CTRL_EXT];
	assign setup_acc = apb_in.psel && apb_in.penable && !pready_q;
	assign done_acc = apb_in.psel && apb_in.penable && pready_q;
	assign wr_acc = done_acc && apb_in.pwrite;
	assign rd_acc = done_acc && !apb_in.pwrite;
	assign full = (level_q == (AW + 1)'(DEPTH));
	assign empty = (level_q == '0);
	assign ovcl = wr_acc && apb_in.paddr == SAC_CTRL_OFS && apb_in.pwdata[SAC_CTRL_OVCLR];
	assign flush = wr_acc && apb_in.paddr == SAC_CTRL_OFS && apb_in.pwdata[SAC_CTRL_FLUSH];
	assign push = adc_done_in && busy_q;
	// pop only the word that was latched, so a push that lands mid-read is never lost
	assign pop = rd_acc && apb_in.paddr == SAC_FIFO_OFS && pop_ok_q;

	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_err = 1'b0;
		case (apb_in.paddr)
			SAC_CTRL_OFS: rd_mux = {26'h0, ctrl_q};
			SAC_STAT_OFS: begin
				rd_mux[SAC_STAT_NE] = !empty;
				rd_mux[SAC_STAT_OVF] = ovf_q;
				rd_mux[SAC_STAT_CH_LSB +: 3] = chan_q;
				rd_mux[SAC_STAT_BUSY] = busy_q;
			end
			SAC_FIFO_OFS: rd_mux = empty ? 32'h0 : {16'h0, mem_q[rp_q]};
			SAC_MODE_OFS: rd_mux = {24'h0, mode_q};
			SAC_CNT0_OFS: rd_mux = {16'h0, cnt_q[0]};
			SAC_CNT0_OFS + 8'h04: rd_mux = {16'h0, cnt_q[1]};
			SAC_CNT0_OFS + 8'h08: rd_mux = {16'h0, cnt_q[2]};
			default: rd_err = 1'b1;
		endcase
	end

	// one wait state: data is latched on the first access cycle, ready follows
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			pop_ok_q <= 1'b0;
		end else begin
			pready_q <= setup_acc;
			pslverr_q <= setup_acc && rd_err;
			pop_ok_q <= setup_acc && !apb_in.pwrite && apb_in.paddr == SAC_FIFO_OFS && !empty;
			if (setup_acc && !apb_in.pwrite)
				prdata_q <= rd_mux;
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			ctrl_q <= SAC_CTRL_RST;
			mode_q <= SAC_MODE_RST;
		end else if (wr_acc) begin
			if (apb_in.paddr == SAC_CTRL_OFS)
				ctrl_q <= apb_in.pwdata[5:0];
			if (apb_in.paddr == SAC_MODE_OFS)
				mode_q <= apb_in.pwdata[7:0];
		end
	end

	// 1 MHz timebase for every counter, never an external clock
	assign tick = (div_q == 7'(TICK_CYC - 1));
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			div_q <= 7'h00;
		else if (tick)
			div_q <= 7'h00;
		else
			div_q <= div_q + 7'h01;
	end

	// counters: output drops on the last count and rises at reload
	for (genvar i = 0; i < SAC_NCNT; i++) begin : g_cnt
		logic sel;
		assign sel = wr_acc && apb_in.paddr == SAC_CNT0_OFS + 8'(4 * i);
		always_ff @(posedge clk_in or posedge sys_rst_in) begin
			if (sys_rst_in) begin
				reload_q[i] <= SAC_CNT_RST;
				cnt_q[i] <= SAC_CNT_RST;
				tout_q[i] <= 1'b1;
			end else if (sel) begin
				// intervals below the minimum would never toggle the output
				reload_q[i] <= (apb_in.pwdata[15:0] < SAC_CNT_MIN) ?
					SAC_CNT_MIN : apb_in.pwdata[15:0];
				cnt_q[i] <= (apb_in.pwdata[15:0] < SAC_CNT_MIN) ?
					SAC_CNT_MIN : apb_in.pwdata[15:0];
				tout_q[i] <= 1'b1;
			end else if (tick && mode_q[i]) begin
				if (cnt_q[i] == 16'h0001) begin
					cnt_q[i] <= reload_q[i];
					tout_q[i] <= 1'b1;
				end else begin
					cnt_q[i] <= cnt_q[i] - 16'h0001;
					tout_q[i] <= (cnt_q[i] != 16'h0002);
				end
			end
		end
	end
	assign timer_out_out = tout_q;

	// conversion triggers
	assign tmr_rise = tout_q[0] && !tout0_prev_q;
	assign ext_rise = external_convert_n && !ext_prev_q;
	assign conv_req = acq_en && (tmr_rise || (ext_en && ext_rise));
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			tout0_prev_q <= 1'b1;
			ext_prev_q <= 1'b1;
		end else begin
			tout0_prev_q <= tout_q[0];
			ext_prev_q <= external_convert_n;
		end
	end

	// a trigger while a conversion is running is dropped, like an overrun converter
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			start_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			start_q <= conv_req && !busy_q;
			if (conv_req && !busy_q)
				busy_q <= 1'b1;
			else if (adc_done_in)
				busy_q <= 1'b0;
		end
	end

	// channel select: loaded while idle, fixed or descending during acquisition
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			chan_q <= 3'h0;
		else if (!acq_en)
			chan_q <= high_ch;
		else if (push && scan_en)
			chan_q <= (chan_q == 3'h0) ? high_ch : chan_q - 3'h1;
	end
	assign adc_out = '{start: start_q, chan: chan_q};

	// result FIFO
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			wp_q <= '0;
			rp_q <= '0;
			level_q <= '0;
		end else if (flush) begin
			wp_q <= '0;
			rp_q <= '0;
			level_q <= '0;
		end else begin
			if (push && !full)
				wp_q <= wp_q + AW'(1);
			if (pop)
				rp_q <= rp_q + AW'(1);
			level_q <= level_q + (AW + 1)'(push && !full) - (AW + 1)'(pop);
		end
	end

	always_ff @(posedge clk_in) begin
		if (push && !full)
			mem_q[wp_q] <= {{(SAC_WORD_W - SAC_ADC_W){adc_data_in[SAC_ADC_W-1]}},
				adc_data_in};
	end

	// set wins over clear so a late overrun is never hidden
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			ovf_q <= 1'b0;
		else if (push && full)
			ovf_q <= 1'b1;
		else if (ovcl || flush)
			ovf_q <= 1'b0;
	end

	assign apb_out = '{prdata: prdata_q, pready: pready_q, pslverr: pslverr_q};

	sequence last_count_s;
		tick && mode_q[0] && cnt_q[0] == 16'h0001 && !(wr_acc &&
			apb_in.paddr == SAC_CNT0_OFS);
	endsequence
	sequence conv_start_s;
		conv_req && !busy_q;
	endsequence

	sign_ext_a: assert property (push && !full |=> mem_q[$past(wp_q)] ==
		{{4{$past(adc_data_in[11])}}, $past(adc_data_in)})
		else $error("stored word not sign extended");
	fifo_ovf_a: assert property (push && full |=> ovf_q &&
		(level_q == $past(level_q) - (AW + 1)'($past(pop)) || $past(flush)))
		else $error("overflow not flagged or data kept");
	not_empty_a: assert property (pready_q && !apb_in.pwrite &&
		$past(apb_in.paddr) == SAC_STAT_OFS |-> prdata_q[SAC_STAT_NE] == ($past(level_q) != 0))
		else $error("status not-empty wrong");
	reload_a: assert property (last_count_s |=> cnt_q[0] == $past(reload_q[0]) && tout_q[0])
		else $error("sample counter did not reload");
	timer_start_a: assert property (conv_start_s |=> start_q && busy_q ##1 !start_q)
		else $error("conversion start missing or long");
	single_hold_a: assert property (acq_en && !scan_en && $past(acq_en) |-> $stable(chan_q))
		else $error("channel moved in single mode");
	scan_step_a: assert property (acq_en && scan_en && push |=>
		chan_q == (($past(chan_q) == 3'h0) ? $past(high_ch) : $past(chan_q) - 3'h1))
		else $error("scan step wrong");
	ovf_hold_a: assert property (ovf_q && !ovcl && !flush |=> ovf_q)
		else $error("overflow flag lost");
	tick_rate_a: assert property (tick |=> !tick ##TICK_GAP tick)
		else $error("timebase faster than expected");
	store_fast_a: assert property (push && !full |=> level_q != 0)
		else $error("result not stored at once");
endmodule // sac_top
`default_nettype wire

//--- testbench/sac_conv_model.sv
// sac_conv_model: converter with input mux facing the acquisition control block.
// assumes one start pulse per conversion and a latency of lat_in cycles (1 or more).
`default_nettype none
module sac_conv_model (
	// clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// control side
	input wire sac_pkg::sac_adc_cmd_t adc_in,
	input wire logic [3:0] lat_in,
	// result side
	output logic done_out,
	output logic [11:0] data_out
);
	timeunit 1ns;
	timeprecision 1ns;
	import sac_pkg::*;
	logic [3:0] wait_q;
	logic [11:0] last_q;
	logic [2:0] ch_q;
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			wait_q <= 4'h0;
			done_out <= 1'b0;
			last_q <= 12'h000;
			ch_q <= 3'h0;
		end else begin
			done_out <= (wait_q == 4'h1);
			if (adc_in.start) begin
				wait_q <= lat_in;
				ch_q <= adc_in.chan;
			end else if (wait_q != 4'h0) begin
				wait_q <= wait_q - 4'h1;
			end
			if (wait_q == 4'h1) begin
				last_q <= {ch_q, 9'h0A5};
			end
		end
	end
	// outside the done cycle the bus shows the inverse, so stale data never matches
	assign data_out = done_out ? last_q : ~last_q;
endmodule // sac_conv_model
`default_nettype wire

//--- testbench/tb_top.sv
// tb_top: self-checking bench for sac_top with a converter model.
// assumes a shortened timer tick of 4 clocks and a one-wait-state APB slave.
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import sac_pkg::*;
	localparam int TICK = 4;
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic ext_n = 1'b1;
	logic done;
	logic [11:0] adc_data;
	logic [3:0] lat = 4'h3;
	logic [2:0] tmr;
	sac_apb_req_t apb_req = '0;
	sac_apb_rsp_t apb_rsp;
	sac_adc_cmd_t adc_cmd;
	int err_total = 0;
	int checked = 0;
	int n_done = 0;
	sac_top #(.DEPTH(16), .TICK_CYC(TICK)) u_sac_top (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.apb_in(apb_req), .apb_out(apb_rsp), .adc_out(adc_cmd), .adc_done_in(done),
		.adc_data_in(adc_data), .external_convert_n(ext_n), .timer_out_out(tmr));
	sac_conv_model u_sac_conv_model (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .adc_in(adc_cmd),
		.lat_in(lat), .done_out(done), .data_out(adc_data));
	initial begin
		forever #5 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		if (done === 1'b1) n_done <= n_done + 1;
	end
	task automatic complete_run();
		if (err_total == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tmo();
		chk(32'h0, 32'h1);
		complete_run();
	endtask
	function automatic logic [31:0] exp_w(input logic [2:0] ch);
		return {16'h0, {4{ch[2]}}, ch, 9'h0A5};
	endfunction
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge clk_in);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge clk_in);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge clk_in);
			n++;
			if (n > 20) tmo();
		end while (apb_rsp.pready !== 1'b1);
		r = apb_rsp.prdata;
		e = apb_rsp.pslverr;
		apb_req <= '0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r & m, exp);
	endtask
	// the done pulse must land within the external-convert latency budget
	task automatic conv_ext();
		int n0, k;
		n0 = n_done;
		k = 0;
		@(posedge clk_in);
		ext_n <= 1'b0;
		@(posedge clk_in);
		ext_n <= 1'b1;
		while (n_done == n0) begin
			@(posedge clk_in);
			k++;
			if (k > SAC_EXT_LAT_CYC) tmo();
		end
	endtask
	task automatic until_fall(output int c);
		c = 0;
		while (tmr[0] !== 1'b1) begin @(posedge clk_in); c++; if (c > 900) tmo(); end
		while (tmr[0] !== 1'b0) begin @(posedge clk_in); c++; if (c > 900) tmo(); end
	endtask
	task automatic t_reset();
		logic [31:0] r;
		logic e;
		chk({29'h0, tmr}, 32'h7);
		rd_chk(SAC_CTRL_OFS, 32'h0, '1);
		rd_chk(SAC_MODE_OFS, 32'h0, '1);
		for (int i = 0; i < 3; i++) rd_chk(SAC_CNT0_OFS + 8'(4 * i), 32'h2, '1);
		apb(1'b0, 8'h1C, 32'h0, r, e);
		chk({e, r[30:0]}, 32'h8000_0000);
		wr(SAC_CNT0_OFS + 8'h04, 32'hFFFF);
		rd_chk(SAC_CNT0_OFS + 8'h04, 32'hFFFF, '1);
		wr(SAC_CNT0_OFS + 8'h04, 32'h1);
		rd_chk(SAC_CNT0_OFS + 8'h04, 32'h2, '1);
		rd_chk(SAC_FIFO_OFS, 32'h0, '1);
	endtask
	task automatic t_single();
		wr(SAC_CTRL_OFS, 32'h14);
		wr(SAC_CTRL_OFS, 32'h35);
		wr(SAC_CTRL_OFS, 32'h29);
		chk({29'h0, adc_cmd.chan}, 32'h5);
		conv_ext();
		rd_chk(SAC_STAT_OFS, 32'h15, 32'h1F);
		rd_chk(SAC_FIFO_OFS, exp_w(3'h5), '1);
		rd_chk(SAC_STAT_OFS, 32'h14, 32'h1F);
	endtask
	task automatic t_scan(input logic [2:0] hi);
		int c, n0, k, h;
		n0 = n_done;
		k = 0;
		h = hi;
		wr(SAC_CTRL_OFS, {27'h0, hi, 2'b10});
		wr(SAC_CTRL_OFS, {27'h0, hi, 2'b11});
		wr(SAC_CNT0_OFS, 32'h3);
		wr(SAC_MODE_OFS, 32'h1);
		until_fall(c);
		until_fall(c);
		chk(c, 3 * TICK);
		while (n_done < n0 + 8) begin @(posedge clk_in); k++; if (k > 2000) tmo(); end
		wr(SAC_MODE_OFS, 32'h0);
		for (int i = 0; i < 8; i++) rd_chk(SAC_FIFO_OFS, exp_w(hi - 3'(i % (h + 1))), '1);
		wr(SAC_CTRL_OFS, 32'h80);
		rd_chk(SAC_STAT_OFS, 32'h0, 32'h3);
	endtask
	// a slow converter here: results stay unread while conversions keep coming
	task automatic t_ovf();
		@(posedge clk_in);
		lat <= 4'h9;
		wr(SAC_CTRL_OFS, 32'h00);
		wr(SAC_CTRL_OFS, 32'h21);
		for (int i = 0; i < 17; i++) conv_ext();
		rd_chk(SAC_STAT_OFS, 32'h3, 32'h3);
		for (int i = 0; i < 16; i++) rd_chk(SAC_FIFO_OFS, exp_w(3'h0), '1);
		rd_chk(SAC_STAT_OFS, 32'h2, 32'h3);
		wr(SAC_CTRL_OFS, 32'h61);
		rd_chk(SAC_STAT_OFS, 32'h0, 32'h3);
	endtask
	initial begin
		repeat (3) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		t_reset();
		t_single();
		t_scan(3'h3);
		t_scan(3'h1);
		t_scan(3'h7);
		t_ovf();
		complete_run();
	end
endmodule // tb_top
`default_nettype wire
